// ==== common/gpsc_pkg.sv ====
package gpsc_pkg;
   // device-wide group states
   typedef enum logic [2:0] {
      DEV_NO_SUPPLY,
      DEV_BACKUP,
      DEV_WAIT_ON,
      DEV_ACTIVE,
      DEV_SLEEP
   } gpsc_dev_state_e;

   // subsystem group states
   typedef enum logic [1:0] {
      GRP_OFF,
      GRP_SLEEP,
      GRP_ACTIVE
   } gpsc_grp_state_e;

   // resource power levels, ordered so that a larger code means more power
   localparam logic [1:0] RES_OFF = 2'h0;
   localparam logic [1:0] RES_LOW = 2'h1;
   localparam logic [1:0] RES_FULL = 2'h2;

   // group indices
   localparam int GRP_APP = 0;
   localparam int GRP_CONN = 1;
   localparam int GRP_MODEM = 2;
   localparam int NUM_GRPS = 3;

   // threshold code width and the two stored code sets
   localparam int THR_W = 6;
   localparam logic [5:0] OFF_THR_HIGH_SET = 6'h0_6;
   localparam logic [5:0] OFF_THR_LOW_SET = 6'h0_1;
   localparam logic [5:0] ON_THR_HIGH_SET = 6'h1_8;
   localparam logic [5:0] ON_THR_LOW_SET = 6'h0_A;

   // voltage selection codes, 50 mV per step from 0.6 V
   localparam int VSEL_W = 7;
   localparam logic [6:0] VSEL_MEM_1V35 = 7'h0_F;
   localparam logic [6:0] VSEL_MEM_1V2 = 7'h0_C;
   localparam logic [6:0] VSEL_AUX_2V8 = 7'h2_C;
   localparam logic [6:0] VSEL_AUX_1V8 = 7'h1_8;
   localparam logic [6:0] VSEL_RESET = 7'h0_0;

   // default slew step: one code per this many cycles
   localparam logic [7:0] SLEW_STEP_RESET = 8'h0_4;
endpackage

// ==== rtl/gpsc_req_decode.sv ====
// turns raw request pins into one active flag per subsystem group
module gpsc_req_decode (
   // raw pins
   input wire logic app_group_request,
   input wire logic conn_group_request_a,
   input wire logic conn_group_request_b,
   input wire logic conn_group_request_c,
   input wire logic modem_group_request,
   // configuration
   input wire logic [2:0] req_mask,
   input wire logic [2:0] req_polarity_low,
   // result
   output logic [2:0] grp_req
);
   logic [2:0] raw;

   // connectivity pins combine before polarity, one shared mask
   always_comb begin
      raw[gpsc_pkg::GRP_APP] = app_group_request;
      raw[gpsc_pkg::GRP_CONN] = conn_group_request_a | conn_group_request_b | conn_group_request_c;
      raw[gpsc_pkg::GRP_MODEM] = modem_group_request;
   end

   // a masked group never requests
   assign grp_req = (raw ^ req_polarity_low) & ~req_mask;
endmodule // gpsc_req_decode

// ==== rtl/gpsc_vramp.sv ====
// ramps a voltage code toward its target, one code per step interval
module gpsc_vramp (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // control
   input wire logic [6:0] target,
   input wire logic [7:0] step_cycles,
   // output
   output logic [6:0] vsel,
   output logic busy
);
   typedef struct packed {
      logic [6:0] v;
      logic [7:0] cnt;
   } gpsc_vr_s;
   gpsc_vr_s q, d;

   // a zero step register would stall, so it is treated as one cycle
   always_comb begin
      d = q;
      if (q.v != target) begin
         if (q.cnt + 8'h0_1 >= step_cycles) begin
            d.cnt = 8'h0_0;
            d.v = (q.v < target) ? q.v + 7'h0_1 : q.v - 7'h0_1;
         end else begin
            d.cnt = q.cnt + 8'h0_1;
         end
      end else begin
         d.cnt = 8'h0_0;
      end
   end

   // registers
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         q <= '{v: gpsc_pkg::VSEL_RESET, cnt: 8'h0_0};
      end else begin
         q <= d;
      end
   end

   assign vsel = q.v;
   assign busy = q.v != target;
endmodule // gpsc_vramp

// ==== rtl/gpsc_top.sv ====
module gpsc_top #(
   parameter int NUM_RES = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // energy source and comparators
   input wire logic main_source_ok,
   input wire logic backup_source_ok,
   input wire logic battery_above_off,
   input wire logic battery_above_on,
   // triggering events and their enables
   input wire logic power_on_event,
   input wire logic power_on_event_en,
   input wire logic request_event_en,
   // subsystem request pins and configuration
   input wire logic app_group_request,
   input wire logic conn_group_request_a,
   input wire logic conn_group_request_b,
   input wire logic conn_group_request_c,
   input wire logic modem_group_request,
   input wire logic [2:0] req_mask,
   input wire logic [2:0] req_polarity_low,
   // group membership of each resource, bit per group
   input wire logic [NUM_RES*3-1:0] res_group_map,
   // boot straps
   input wire logic battery_chem_strap,
   input wire logic memory_supply_strap,
   input wire logic flash_voltage_strap,
   input wire logic platform_sequence_strap,
   input wire logic variant_sel,
   // voltage scaling port command and ordinary voltage register
   input wire logic scale_cmd_valid,
   input wire logic scale_cmd_sel,
   input wire logic [6:0] scale_cmd_vsel,
   input wire logic [7:0] slew_step,
   input wire logic [6:0] plain_vsel_reg,
   // state outputs
   output gpsc_pkg::gpsc_dev_state_e dev_state,
   output logic [5:0] grp_state,
   output logic [NUM_RES*2-1:0] res_level,
   output logic system_reset_out,
   output logic ctrl_reset_n,
   output logic keepalive_on,
   // startup configuration outputs
   output logic [5:0] battery_switch_off_threshold,
   output logic [5:0] battery_switch_on_threshold,
   output logic [6:0] memory_supply_regulator,
   output logic memory_supply_in_seq,
   output logic [6:0] aux_regulator_one,
   output logic aux_one_enable,
   output logic aux_one_pulldown,
   output logic [6:0] scaled_vsel_a,
   output logic [6:0] scaled_vsel_b,
   output logic [6:0] plain_vsel
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // level that one group state asks of its resources
   function automatic logic [1:0] gpsc_level(input logic [1:0] st);
      case (st)
         gpsc_pkg::GRP_ACTIVE: gpsc_level = gpsc_pkg::RES_FULL;
         gpsc_pkg::GRP_SLEEP: gpsc_level = gpsc_pkg::RES_LOW;
         default: gpsc_level = gpsc_pkg::RES_OFF;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      gpsc_pkg::gpsc_dev_state_e dev;
      logic [5:0] grp;
      logic [NUM_RES*2-1:0] res;
      logic sysrst;
      logic ctlrst_n;
      logic keep;
      logic straps_done;
      logic [5:0] off_thr;
      logic [5:0] on_thr;
      logic [6:0] mem_v;
      logic mem_seq;
      logic [6:0] aux_v;
      logic aux_en;
      logic aux_pd;
      logic [6:0] tgt_a;
      logic [6:0] tgt_b;
      logic [6:0] sva;
      logic [6:0] svb;
      logic [6:0] pv;
   } gpsc_top_s;
   gpsc_top_s q, d;

   logic [2:0] grp_req;
   logic [6:0] ramp_a, ramp_b;
   logic [1:0] lvl [NUM_RES];
   logic all_sleep, any_active;

   ////////////////////////////////////////////////////////////////////////////
   // submodules

   gpsc_req_decode u_req (
      .app_group_request(app_group_request),
      .conn_group_request_a(conn_group_request_a),
      .conn_group_request_b(conn_group_request_b),
      .conn_group_request_c(conn_group_request_c),
      .modem_group_request(modem_group_request),
      .req_mask(req_mask),
      .req_polarity_low(req_polarity_low),
      .grp_req(grp_req)
   );

   // two scalable switchers; ramps follow their own targets only
   gpsc_vramp u_ramp_a (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .target(q.tgt_a),
      .step_cycles(slew_step),
      .vsel(ramp_a),
      .busy()
   );
   gpsc_vramp u_ramp_b (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .target(q.tgt_b),
      .step_cycles(slew_step),
      .vsel(ramp_b),
      .busy()
   );

   ////////////////////////////////////////////////////////////////////////////
   // arbitration of shared resources

   // highest level among member groups wins so no active group loses supply
   generate
      for (genvar r = 0; r < NUM_RES; r++) begin : g_res
         always_comb begin
            lvl[r] = gpsc_pkg::RES_OFF;
            for (int g = 0; g < gpsc_pkg::NUM_GRPS; g++) begin
               if (res_group_map[r*3+g] && gpsc_level(q.grp[g*2 +: 2]) > lvl[r]) begin
                  lvl[r] = gpsc_level(q.grp[g*2 +: 2]);
               end
            end
         end
      end
   endgenerate

   // group summaries for the device-wide group
   always_comb begin
      all_sleep = 1'b1;
      any_active = 1'b0;
      for (int g = 0; g < gpsc_pkg::NUM_GRPS; g++) begin
         if (q.grp[g*2 +: 2] != gpsc_pkg::GRP_SLEEP) all_sleep = 1'b0;
         if (q.grp[g*2 +: 2] == gpsc_pkg::GRP_ACTIVE) any_active = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      d = q;
      // device-wide state machine
      case (q.dev)
         gpsc_pkg::DEV_NO_SUPPLY: begin
            if (main_source_ok) d.dev = gpsc_pkg::DEV_WAIT_ON;
            else if (backup_source_ok) d.dev = gpsc_pkg::DEV_BACKUP;
         end
         gpsc_pkg::DEV_BACKUP: begin
            if (main_source_ok) d.dev = gpsc_pkg::DEV_WAIT_ON;
            else if (!backup_source_ok) d.dev = gpsc_pkg::DEV_NO_SUPPLY;
         end
         gpsc_pkg::DEV_WAIT_ON: begin
            // switch-on needs an enabled event and the rising threshold
            if (power_on_event && power_on_event_en && battery_above_on) d.dev = gpsc_pkg::DEV_ACTIVE;
         end
         gpsc_pkg::DEV_ACTIVE: begin
            if (all_sleep) d.dev = gpsc_pkg::DEV_SLEEP;
         end
         gpsc_pkg::DEV_SLEEP: begin
            if (!all_sleep) d.dev = gpsc_pkg::DEV_ACTIVE;
         end
         default: d.dev = gpsc_pkg::DEV_NO_SUPPLY;
      endcase
      // loss of sources or a falling battery overrides everything
      if (!main_source_ok) begin
         d.dev = backup_source_ok ? gpsc_pkg::DEV_BACKUP : gpsc_pkg::DEV_NO_SUPPLY;
      end else if (!battery_above_off && (q.dev == gpsc_pkg::DEV_ACTIVE || q.dev == gpsc_pkg::DEV_SLEEP)) begin
         d.dev = gpsc_pkg::DEV_WAIT_ON;
      end

      // subsystem groups follow their requests only while the device runs
      for (int g = 0; g < gpsc_pkg::NUM_GRPS; g++) begin
         if (d.dev == gpsc_pkg::DEV_ACTIVE || d.dev == gpsc_pkg::DEV_SLEEP) begin
            if (q.dev == gpsc_pkg::DEV_WAIT_ON) begin
               d.grp[g*2 +: 2] = gpsc_pkg::GRP_ACTIVE;
            end else if (request_event_en) begin
               d.grp[g*2 +: 2] = grp_req[g] ? gpsc_pkg::GRP_ACTIVE : gpsc_pkg::GRP_SLEEP;
            end
         end else begin
            d.grp[g*2 +: 2] = gpsc_pkg::GRP_OFF;
         end
      end

      // resource levels from arbitration
      for (int r = 0; r < NUM_RES; r++) begin
         d.res[r*2 +: 2] = lvl[r];
      end

      // resets and keep-alive; system reset stays released in sleep so context survives
      d.ctlrst_n = (q.dev != gpsc_pkg::DEV_NO_SUPPLY) && (q.dev != gpsc_pkg::DEV_BACKUP);
      d.sysrst = !(q.dev == gpsc_pkg::DEV_ACTIVE || q.dev == gpsc_pkg::DEV_SLEEP);
      d.keep = q.dev != gpsc_pkg::DEV_NO_SUPPLY;

      // straps caught once at the first valid-source cycle
      if (!q.straps_done && main_source_ok) begin
         d.straps_done = 1'b1;
         d.off_thr = battery_chem_strap ? gpsc_pkg::OFF_THR_LOW_SET : gpsc_pkg::OFF_THR_HIGH_SET;
         d.on_thr = battery_chem_strap ? gpsc_pkg::ON_THR_LOW_SET : gpsc_pkg::ON_THR_HIGH_SET;
         if (variant_sel) begin
            d.mem_seq = memory_supply_strap;
            d.mem_v = gpsc_pkg::VSEL_MEM_1V2;
         end else begin
            d.mem_seq = 1'b1;
            d.mem_v = memory_supply_strap ? gpsc_pkg::VSEL_MEM_1V2 : gpsc_pkg::VSEL_MEM_1V35;
         end
         d.aux_v = flash_voltage_strap ? gpsc_pkg::VSEL_AUX_1V8 : gpsc_pkg::VSEL_AUX_2V8;
         d.aux_en = platform_sequence_strap;
         d.aux_pd = !platform_sequence_strap;
      end

      // scaling commands touch only voltage targets, never group state
      if (scale_cmd_valid && q.dev != gpsc_pkg::DEV_NO_SUPPLY && q.dev != gpsc_pkg::DEV_BACKUP) begin
         if (scale_cmd_sel) d.tgt_b = scale_cmd_vsel;
         else d.tgt_a = scale_cmd_vsel;
      end
      d.sva = ramp_a;
      d.svb = ramp_b;
      d.pv = plain_vsel_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         q <= '0;
         q.dev <= gpsc_pkg::DEV_NO_SUPPLY;
         q.sysrst <= 1'b1;
         q.aux_pd <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flip-flops
   assign dev_state = q.dev;
   assign grp_state = q.grp;
   assign res_level = q.res;
   assign system_reset_out = q.sysrst;
   assign ctrl_reset_n = q.ctlrst_n;
   assign keepalive_on = q.keep;
   assign battery_switch_off_threshold = q.off_thr;
   assign battery_switch_on_threshold = q.on_thr;
   assign memory_supply_regulator = q.mem_v;
   assign memory_supply_in_seq = q.mem_seq;
   assign aux_regulator_one = q.aux_v;
   assign aux_one_enable = q.aux_en;
   assign aux_one_pulldown = q.aux_pd;
   assign scaled_vsel_a = q.sva;
   assign scaled_vsel_b = q.svb;
   assign plain_vsel = q.pv;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_sleep_needs_all: assert property (@(posedge clk_sys) disable iff (!rstn)
      (dev_state == gpsc_pkg::DEV_SLEEP) |-> $past(all_sleep))
      else $error("device sleep entered without all groups asleep");
   a_waiton_groups_off: assert property (@(posedge clk_sys) disable iff (!rstn)
      (q.dev == gpsc_pkg::DEV_WAIT_ON && $past(q.dev) == gpsc_pkg::DEV_WAIT_ON) |-> grp_state == 6'h0_0)
      else $error("subsystem group not off in wait-on");
   a_nosupply_source: assert property (@(posedge clk_sys) disable iff (!rstn)
      ($past(!main_source_ok) && $past(!backup_source_ok)) |-> dev_state == gpsc_pkg::DEV_NO_SUPPLY)
      else $error("no-supply not taken without a source");
   a_backup_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
      (dev_state == gpsc_pkg::DEV_BACKUP) |=> keepalive_on && !ctrl_reset_n)
      else $error("backup state does not keep alive only");
   a_active_reset: assert property (@(posedge clk_sys) disable iff (!rstn)
      (q.dev == gpsc_pkg::DEV_ACTIVE && any_active) |=> !system_reset_out)
      else $error("system reset held while group active");
   a_wake_needs_event: assert property (@(posedge clk_sys) disable iff (!rstn)
      ($past(q.dev) == gpsc_pkg::DEV_WAIT_ON && q.dev == gpsc_pkg::DEV_ACTIVE)
      |-> $past(power_on_event && power_on_event_en))
      else $error("switch-on without an enabled event");
   a_thr_strap: assert property (@(posedge clk_sys) disable iff (!rstn)
      ($rose(q.straps_done) && $past(battery_chem_strap)) |-> battery_switch_off_threshold == gpsc_pkg::OFF_THR_LOW_SET)
      else $error("battery strap did not pick low thresholds");
   a_aux_strap: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(q.straps_done) |-> aux_one_enable == $past(platform_sequence_strap) && aux_one_pulldown != aux_one_enable)
      else $error("aux regulator enable does not follow strap");
   a_scale_no_state: assert property (@(posedge clk_sys) disable iff (!rstn)
      (scale_cmd_valid && $stable(grp_req) && q.dev == gpsc_pkg::DEV_ACTIVE && main_source_ok && battery_above_off
       && !all_sleep && $past(q.dev) == gpsc_pkg::DEV_ACTIVE) |=> $stable(q.dev))
      else $error("scaling command changed device state");
   a_mask_blocks_req: assert property (@(posedge clk_sys) disable iff (!rstn)
      (q.dev == gpsc_pkg::DEV_ACTIVE && main_source_ok && battery_above_off && request_event_en && req_mask[0])
      |=> grp_state[1:0] == gpsc_pkg::GRP_SLEEP) else $error("masked app request still took effect");
   a_keep_nosupply: assert property (@(posedge clk_sys) disable iff (!rstn)
      (dev_state == gpsc_pkg::DEV_NO_SUPPLY && $past(dev_state) == gpsc_pkg::DEV_NO_SUPPLY) |-> !keepalive_on)
      else $error("keep-alive powered with no source");
   a_sleep_keeps_ctx: assert property (@(posedge clk_sys) disable iff (!rstn)
      (q.dev == gpsc_pkg::DEV_SLEEP) |=> !system_reset_out)
      else $error("system reset asserted during sleep");
endmodule // gpsc_top

// ==== bench/gpsc_subsys_model.sv ====
// behavioural stand-in for the three subsystems driving their request pins
module gpsc_subsys_model (
   // wishes of each subsystem, bit per group
   input wire logic [2:0] want_active,
   input wire logic [2:0] pol_low,
   input wire logic [1:0] conn_pick,
   // request pins
   output logic app_group_request,
   output logic conn_group_request_a,
   output logic conn_group_request_b,
   output logic conn_group_request_c,
   output logic modem_group_request
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////
   // pins follow the configured polarity; idle connectivity pins sit inactive
   assign app_group_request = want_active[0] ^ pol_low[0];
   assign modem_group_request = want_active[2] ^ pol_low[2];
   // active low: the device inverts the OR, so all three pins move together
   assign conn_group_request_a = pol_low[1] ? !want_active[1] : (want_active[1] && conn_pick == 2'h0);
   assign conn_group_request_b = pol_low[1] ? !want_active[1] : (want_active[1] && conn_pick == 2'h1);
   assign conn_group_request_c = pol_low[1] ? !want_active[1] : (want_active[1] && conn_pick == 2'h2);
endmodule // gpsc_subsys_model

// ==== bench/tb_group_power_state_control.sv ====
module tb_group_power_state_control;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin failures++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
   typedef struct packed {logic [2:0] want; logic [2:0] mask; logic [2:0] pol; logic [1:0] pick; logic [2:0] act;} gpsc_row_s;
   logic clk_sys, rstn = 0, main_source_ok = 0, backup_source_ok = 0, battery_above_off = 0, battery_above_on = 0;
   logic power_on_event = 0, power_on_event_en = 0, request_event_en = 0, variant_sel = 0;
   logic battery_chem_strap = 0, memory_supply_strap = 0, flash_voltage_strap = 0, platform_sequence_strap = 0;
   logic scale_cmd_valid = 0, scale_cmd_sel = 0, system_reset_out, ctrl_reset_n, keepalive_on;
   logic app_group_request, conn_group_request_a, conn_group_request_b, conn_group_request_c, modem_group_request;
   logic [2:0] req_mask = '0, req_polarity_low = '0, want_active = '0;
   logic [1:0] conn_pick = '0;
   logic [11:0] res_group_map = 12'h711;
   logic [6:0] scale_cmd_vsel = '0, plain_vsel_reg = '0, memory_supply_regulator, aux_regulator_one;
   logic [6:0] scaled_vsel_a, scaled_vsel_b, plain_vsel;
   logic [7:0] slew_step = 8'h01, res_level;
   logic [5:0] grp_state, battery_switch_off_threshold, battery_switch_on_threshold;
   logic memory_supply_in_seq, aux_one_enable, aux_one_pulldown;
   gpsc_pkg::gpsc_dev_state_e dev_state;
   int failures = 0, num_checks = 0, cycles = 0, n;
   // shared resource 3 sits in app and conn, the others in one group each
   gpsc_row_s rows [9] = '{'{3'h7, 3'h0, 3'h0, 2'h0, 3'h7}, '{3'h1, 3'h0, 3'h0, 2'h1, 3'h1},
      '{3'h2, 3'h0, 3'h0, 2'h2, 3'h2}, '{3'h4, 3'h0, 3'h0, 2'h0, 3'h4}, '{3'h7, 3'h2, 3'h0, 2'h0, 3'h5},
      '{3'h7, 3'h5, 3'h0, 2'h1, 3'h2}, '{3'h3, 3'h0, 3'h7, 2'h1, 3'h3}, '{3'h0, 3'h0, 3'h0, 2'h0, 3'h0},
      '{3'h2, 3'h0, 3'h2, 2'h0, 3'h2}};
   ////////////////////////////////////////////////////////////////////////
   gpsc_top #(.NUM_RES(4)) dut (.clk_sys, .rstn, .main_source_ok, .backup_source_ok, .battery_above_off,
      .battery_above_on, .power_on_event, .power_on_event_en, .request_event_en, .app_group_request,
      .conn_group_request_a, .conn_group_request_b, .conn_group_request_c, .modem_group_request, .req_mask,
      .req_polarity_low, .res_group_map, .battery_chem_strap, .memory_supply_strap, .flash_voltage_strap,
      .platform_sequence_strap, .variant_sel, .scale_cmd_valid, .scale_cmd_sel, .scale_cmd_vsel, .slew_step,
      .plain_vsel_reg, .dev_state, .grp_state, .res_level, .system_reset_out, .ctrl_reset_n, .keepalive_on,
      .battery_switch_off_threshold, .battery_switch_on_threshold, .memory_supply_regulator,
      .memory_supply_in_seq, .aux_regulator_one, .aux_one_enable, .aux_one_pulldown, .scaled_vsel_a,
      .scaled_vsel_b, .plain_vsel);
   gpsc_subsys_model partner (.want_active, .pol_low(req_polarity_low), .conn_pick, .app_group_request,
      .conn_group_request_a, .conn_group_request_b, .conn_group_request_c, .modem_group_request);
   ////////////////////////////////////////////////////////////////////////
   // clock, and a ceiling well above the roughly 120 cycles the run needs
   initial begin
      clk_sys = 0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // inputs move a fixed 2 ns after the edge, so outputs are settled there
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #2;
   endtask
   function automatic logic [5:0] grp_of(input logic [2:0] act);
      for (int g = 0; g < 3; g++) grp_of[2*g +: 2] = act[g] ? 2'h2 : 2'h1;
   endfunction
   // a shared resource follows its most demanding group
   function automatic logic [7:0] lvl_of(input logic [2:0] act);
      logic [1:0] l;
      lvl_of = '0;
      for (int r = 0; r < 4; r++) begin
         l = 2'h0;
         for (int g = 0; g < 3; g++) if (res_group_map[r*3+g]) l = (act[g] || l == 2'h2) ? 2'h2 : 2'h1;
         lvl_of[r*2 +: 2] = l;
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // power up from reset with the given straps and bring the device active
   task automatic boot(input logic [3:0] s, input logic v);
      rstn = 0;
      main_source_ok = 0;
      request_event_en = 0;
      power_on_event_en = 0;
      {platform_sequence_strap, flash_voltage_strap, memory_supply_strap, battery_chem_strap} = s;
      variant_sel = v;
      cyc(2);
      `CHK("dev reset", gpsc_pkg::DEV_NO_SUPPLY, dev_state)
      `CHK("sysrst reset", 1'b1, system_reset_out)
      `CHK("ctrl reset", 1'b0, ctrl_reset_n)
      rstn = 1;
      cyc(1);
      main_source_ok = 1;
      battery_above_off = 1;
      power_on_event = 1;
      battery_above_on = 1;
      cyc(3);
      `CHK("wait on", gpsc_pkg::DEV_WAIT_ON, dev_state)
      `CHK("ctrl run", 1'b1, ctrl_reset_n)
      `CHK("grp off", 6'h00, grp_state)
      power_on_event_en = 1;
      battery_above_on = 0;
      cyc(3);
      `CHK("below on", gpsc_pkg::DEV_WAIT_ON, dev_state)
      battery_above_on = 1;
      cyc(1);
      power_on_event = 0;
      cyc(2);
      `CHK("active", gpsc_pkg::DEV_ACTIVE, dev_state)
      `CHK("grp active", 6'h2a, grp_state)
      `CHK("sysrst free", 1'b0, system_reset_out)
      `CHK("res full", lvl_of(3'h7), res_level)
      `CHK("off thr", s[0] ? gpsc_pkg::OFF_THR_LOW_SET : gpsc_pkg::OFF_THR_HIGH_SET, battery_switch_off_threshold)
      `CHK("on thr", s[0] ? gpsc_pkg::ON_THR_LOW_SET : gpsc_pkg::ON_THR_HIGH_SET, battery_switch_on_threshold)
      `CHK("mem seq", v ? s[1] : 1'b1, memory_supply_in_seq)
      if (!v || s[1]) `CHK("mem v", s[1] ? gpsc_pkg::VSEL_MEM_1V2 : gpsc_pkg::VSEL_MEM_1V35, memory_supply_regulator)
      `CHK("aux v", s[2] ? gpsc_pkg::VSEL_AUX_1V8 : gpsc_pkg::VSEL_AUX_2V8, aux_regulator_one)
      `CHK("aux en", s[3], aux_one_enable)
      `CHK("aux pd", !s[3], aux_one_pulldown)
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      boot(4'h0, 1'b0);
      boot(4'h0, 1'b1);
      boot(4'hf, 1'b1);
      // ordinary request cases
      request_event_en = 1;
      plain_vsel_reg = 7'h33;
      foreach (rows[i]) begin
         {want_active, req_mask, req_polarity_low, conn_pick} = {rows[i].want, rows[i].mask, rows[i].pol, rows[i].pick};
         cyc(4);
         `CHK("grp", grp_of(rows[i].act), grp_state)
         `CHK("dev", rows[i].act != 3'h0 ? gpsc_pkg::DEV_ACTIVE : gpsc_pkg::DEV_SLEEP, dev_state)
         `CHK("res", lvl_of(rows[i].act), res_level)
         `CHK("sysrst run", 1'b0, system_reset_out)
      end
      `CHK("plain", 7'h33, plain_vsel)
      // scaling ramps gradually and leaves group states alone
      slew_step = 8'h02;
      scale_cmd_vsel = 7'h10;
      scale_cmd_valid = 1;
      cyc(1);
      scale_cmd_valid = 0;
      n = 0;
      while (scaled_vsel_a !== 7'h10 && n < 200) begin
         cyc(1);
         n++;
      end
      `CHK("ramp slow", 1'b1, n >= 30 && n < 200)
      `CHK("other reg", 7'h00, scaled_vsel_b)
      `CHK("scale grp", grp_of(3'h2), grp_state)
      // requests ignored while their event source is disabled
      request_event_en = 0;
      want_active = 3'h0;
      cyc(4);
      `CHK("req off", grp_of(3'h2), grp_state)
      battery_above_off = 0;
      cyc(3);
      `CHK("switch off", gpsc_pkg::DEV_WAIT_ON, dev_state)
      `CHK("held off", 6'h00, grp_state)
      `CHK("sysrst held", 1'b1, system_reset_out)
      main_source_ok = 0;
      backup_source_ok = 1;
      cyc(1);
      // a scaling command while on backup must not move regulator b
      scale_cmd_sel = 1;
      scale_cmd_valid = 1;
      cyc(2);
      `CHK("backup", gpsc_pkg::DEV_BACKUP, dev_state)
      `CHK("keepalive", 1'b1, keepalive_on)
      scale_cmd_valid = 0;
      backup_source_ok = 0;
      cyc(3);
      `CHK("no supply", gpsc_pkg::DEV_NO_SUPPLY, dev_state)
      `CHK("scale refused", 7'h00, scaled_vsel_b)
      final_report();
   end
endmodule // tb_group_power_state_control
